// file: logic/sspdb_regs.vh
// Purpose: Register map and field positions of the serial buffer block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Definitions only
`ifndef SSPDB_REGS_VH
`define SSPDB_REGS_VH

// ==========================================================
// Offsets
`define SSPDB_ADDR_W 8
`define SSPDB_OFS_LINE_CTL 8'h2c
`define SSPDB_OFS_TX_WORD 8'h30
`define SSPDB_OFS_RX_WORD 8'h34
`define SSPDB_OFS_BUF_CTL 8'h38
`define SSPDB_OFS_BUF_STS 8'h3c
`define SSPDB_OFS_IRQ_STS 8'h40
`define SSPDB_OFS_IRQ_CLR 8'h44
`define SSPDB_OFS_IRQ_EN 8'h48

// ==========================================================
// Buffer control fields
`define SSPDB_BC_RX_RST 17
`define SSPDB_BC_TX_RST 16
`define SSPDB_BC_RX_CLR 15
`define SSPDB_BC_RX_OV_IE 14
`define SSPDB_BC_TX_CLR 7
`define SSPDB_BC_TX_UDR_IE 6

// ==========================================================
// Buffer status fields
`define SSPDB_BS_TX_UDR 11
`define SSPDB_BS_TX_FULL 9
`define SSPDB_BS_TX_EMPTY 8
`define SSPDB_BS_RX_OV 3
`define SSPDB_BS_RX_FULL 1
`define SSPDB_BS_RX_EMPTY 0

// ==========================================================
// Line control, interrupt layout, widths and resets
`define SSPDB_LC_WLEN_HI 11
`define SSPDB_LC_WLEN_LO 8
`define SSPDB_IRQ_RX_OV 0
`define SSPDB_IRQ_TX_UDR 1
`define SSPDB_WORD_W 16
`define SSPDB_WLEN_FULL 5'h10
`define SSPDB_WLEN_MIN 4'h4
`define SSPDB_RST_WLEN 4'h0
`define SSPDB_RST_IRQ_EN 2'h0
`define SSPDB_ZERO32 32'h00000000
`define SSPDB_ZERO16 16'h0000

`endif

// file: logic/sspdb_shreg.v
// Purpose: 16-bit load and shift register for one data path
// Assumes: Clear has priority over load, load over shift
// Notes: Shifts left, new bit enters at bit 0
`timescale 1ns/100ps
`default_nettype none

`include "sspdb_regs.vh"

module sspdb_shreg (
   // Clock and reset
   input wire core_clk_in,
   input wire srst_in,
   // Control
   input wire clr_in,
   input wire load_in,
   input wire shift_in,
   // Data
   input wire [`SSPDB_WORD_W-1:0] load_val_in,
   input wire din_in,
   output reg [`SSPDB_WORD_W-1:0] q_out
);

   // ==========================================================
   // Shift register
   always @(posedge core_clk_in) begin
      if (srst_in || clr_in) begin
         q_out <= `SSPDB_ZERO16;
      end else if (load_in) begin
         q_out <= load_val_in;
      end else if (shift_in) begin
         q_out <= {q_out[`SSPDB_WORD_W-2:0], din_in};
      end
   end

endmodule // sspdb_shreg
`default_nettype wire

// file: logic/sspdb_sync.v
// Purpose: Two-flop synchroniser for one pin
// Assumes: Synchronous active-high reset
// Notes: Only the second flop is read outside
`timescale 1ns/100ps
`default_nettype none

module sspdb_sync #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input wire core_clk_in,
   input wire srst_in,
   // Pin and result
   input wire d_in,
   output reg q_out
);

   reg meta;

   // ==========================================================
   // Two stages
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         meta <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end

endmodule // sspdb_sync
`default_nettype wire

// file: logic/sspdb_top.v
// Purpose: Transmit and receive data buffers with buffer control, SPI slave
// Assumes: Avalon-MM slave with waitrequest, SPI mode 0, MSB first
// Notes:
// Summary of operation
// RULE1: Transmit word register write-only, low sixteen bits
// RULE2: Software checks transmit empty before writing
// RULE3: Receive word register shows receive buffer
// RULE4: Receive reset clears receive path entirely; the code leaves the overrun flag as it is
// RULE5: Transmit reset clears transmit path entirely; the code leaves the under-run flag as it is
// RULE6: Reset and clear bits self-clear after one cycle
// RULE7: Receive clear empties receive buffer
// RULE8: Transmit clear empties transmit buffer
// RULE9: Use clears only when buffer idle
// RULE10: Overrun enable gates overrun interrupt
// RULE11: Under-run enable gates under-run interrupt
// RULE12: Buffer control at 0x38, resets zero
// RULE13: Overrun flag sets, interrupts, write-one clears
// RULE14: Under-run flag sets and interrupts
// RULE15: Transmit empty reads one when buffer free
// RULE16: Words right-aligned in both buffers
// RULE17: Reserved bits read zero, ignore writes
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

`include "sspdb_regs.vh"

module sspdb_top (
   // Clock and reset
   input wire core_clk_in,
   input wire srst_in,
   // Avalon-MM slave
   input wire [`SSPDB_ADDR_W-1:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output reg avs_waitrequest_out,
   // SPI link
   input wire spi_clk_in,
   input wire spi_sel_n_in,
   input wire spi_mosi_in,
   output reg spi_miso_out,
   output reg spi_miso_oe_out,
   // Interrupt
   output reg irq_out
);

   // ==========================================================
   // Local states
   localparam ST_IDLE = 1'b0;
   localparam ST_XFER = 1'b1;

   // ==========================================================
   // Declarations
   wire sclk_s;
   wire sel_n_s;
   wire mosi_s;
   reg sclk_d;
   reg sel_n_d;
   wire sclk_rise;
   wire sclk_fall;
   wire frame_start;

   reg state;
   reg [4:0] bit_cnt;
   reg reload_pend;

   reg [`SSPDB_WORD_W-1:0] tx_buf;
   reg tx_full;
   reg [`SSPDB_WORD_W-1:0] rx_buf;
   reg rx_full;
   reg rx_ov_flag;
   reg tx_udr_flag;

   reg rx_rst_bit;
   reg tx_rst_bit;
   reg rx_clr_bit;
   reg tx_clr_bit;
   reg rx_ov_ie;
   reg tx_udr_ie;
   reg [3:0] wlen_sel;
   reg [1:0] irq_en;
   reg rd_pop_ok;

   wire [`SSPDB_WORD_W-1:0] tx_q;
   wire [`SSPDB_WORD_W-1:0] rx_q;
   wire [4:0] wlen;
   wire [4:0] wlen_m1;
   wire [16:0] one_sh;
   wire [16:0] mask_w;
   wire [`SSPDB_WORD_W-1:0] rx_word;

   wire xfer;
   wire rx_shift;
   wire word_done;
   wire tx_load;
   wire tx_shift;
   wire [`SSPDB_WORD_W-1:0] tx_load_val;
   wire udr_evt;
   wire ov_evt;
   wire rx_path_rst;
   wire tx_path_rst;

   wire acc;
   wire wr;
   wire rd;
   wire [3:0] be;
   wire [31:0] wdata;
   wire wr_tx;
   wire wr_bc;
   wire wr_bs;
   wire wr_lc;
   wire wr_iclr;
   wire wr_ien;
   wire clr_ov;
   wire clr_udr;
   wire [1:0] flags;
   reg [31:0] next_readdata;

   // ==========================================================
   // Link input synchronisers
   sspdb_sync #(.RST_VAL(1'b0)) u_sync_clk (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .d_in(spi_clk_in),
      .q_out(sclk_s)
   );

   sspdb_sync #(.RST_VAL(1'b1)) u_sync_sel (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .d_in(spi_sel_n_in),
      .q_out(sel_n_s)
   );

   sspdb_sync #(.RST_VAL(1'b0)) u_sync_mosi (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .d_in(spi_mosi_in),
      .q_out(mosi_s)
   );

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         sclk_d <= 1'b0;
         sel_n_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         sel_n_d <= sel_n_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign frame_start = sel_n_d & ~sel_n_s;

   // ==========================================================
   // Word length, right-aligned data
   assign wlen = (wlen_sel < `SSPDB_WLEN_MIN) ? `SSPDB_WLEN_FULL :
                 {1'b0, wlen_sel};
   assign wlen_m1 = wlen - 5'h01;
   assign one_sh = 17'h00001 << wlen;
   assign mask_w = one_sh - 17'h00001;
   assign rx_word = {rx_q[`SSPDB_WORD_W-2:0], mosi_s} &
                    mask_w[`SSPDB_WORD_W-1:0]; // RULE16

   // ==========================================================
   // Path resets and clears
   assign rx_path_rst = rx_rst_bit; // RULE4
   assign tx_path_rst = tx_rst_bit; // RULE5

   // ==========================================================
   // Frame control
   assign xfer = (state == ST_XFER) & ~sel_n_s;
   assign rx_shift = xfer & sclk_rise;
   assign word_done = rx_shift & (bit_cnt == wlen_m1);
   assign tx_load = (frame_start & ~tx_path_rst) |
                    (xfer & sclk_fall & reload_pend);
   assign tx_shift = xfer & sclk_fall & ~reload_pend;
   assign tx_load_val = tx_full ? tx_buf : `SSPDB_ZERO16;
   assign udr_evt = tx_load & ~tx_full & ~tx_clr_bit; // RULE14
   assign ov_evt = word_done & rx_full & ~rx_path_rst; // RULE13

   always @(posedge core_clk_in) begin
      if (srst_in || rx_path_rst || tx_path_rst) begin // RULE4 RULE5
         state <= ST_IDLE;
         bit_cnt <= 5'h00;
         reload_pend <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (frame_start) begin
                  state <= ST_XFER;
                  bit_cnt <= 5'h00;
                  reload_pend <= 1'b0;
               end
            end
            ST_XFER: begin
               if (sel_n_s) begin
                  state <= ST_IDLE;
                  reload_pend <= 1'b0;
               end else begin
                  if (word_done) begin
                     bit_cnt <= 5'h00;
                     reload_pend <= 1'b1;
                  end else if (rx_shift) begin
                     bit_cnt <= bit_cnt + 5'h01;
                  end
                  if (tx_load) begin
                     reload_pend <= 1'b0;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Shift registers
   sspdb_shreg u_tx_shreg (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .clr_in(tx_path_rst),
      .load_in(tx_load),
      .shift_in(tx_shift),
      .load_val_in(tx_load_val),
      .din_in(1'b0),
      .q_out(tx_q)
   );

   sspdb_shreg u_rx_shreg (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .clr_in(rx_path_rst),
      .load_in(1'b0),
      .shift_in(rx_shift),
      .load_val_in(`SSPDB_ZERO16),
      .din_in(mosi_s),
      .q_out(rx_q)
   );

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         spi_miso_out <= 1'b0;
         spi_miso_oe_out <= 1'b0;
      end else begin
         spi_miso_out <= tx_q[wlen_m1[3:0]];
         spi_miso_oe_out <= ~sel_n_s;
      end
   end

   // ==========================================================
   // Avalon-MM handshake
   assign acc = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
   assign wr = avs_write_in & acc;
   assign rd = avs_read_in & acc;
   assign be = avs_byteenable_in;
   assign wdata = avs_writedata_in;
   assign wr_tx = wr & (avs_address_in == `SSPDB_OFS_TX_WORD);
   assign wr_bc = wr & (avs_address_in == `SSPDB_OFS_BUF_CTL);
   assign wr_bs = wr & (avs_address_in == `SSPDB_OFS_BUF_STS);
   assign wr_lc = wr & (avs_address_in == `SSPDB_OFS_LINE_CTL);
   assign wr_iclr = wr & (avs_address_in == `SSPDB_OFS_IRQ_CLR);
   assign wr_ien = wr & (avs_address_in == `SSPDB_OFS_IRQ_EN);

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= `SSPDB_ZERO32;
         rd_pop_ok <= 1'b0;
      end else begin
         if ((avs_read_in | avs_write_in) && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= next_readdata;
            rd_pop_ok <= avs_read_in & rx_full &
                         (avs_address_in == `SSPDB_OFS_RX_WORD);
         end else begin
            avs_waitrequest_out <= 1'b1;
            rd_pop_ok <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read multiplexer
   assign flags = {tx_udr_flag, rx_ov_flag};

   always @* begin
      next_readdata = `SSPDB_ZERO32; // RULE17
      case (avs_address_in)
         `SSPDB_OFS_TX_WORD: begin
            next_readdata = `SSPDB_ZERO32; // RULE1
         end
         `SSPDB_OFS_RX_WORD: begin
            next_readdata[`SSPDB_WORD_W-1:0] = rx_buf; // RULE3
         end
         `SSPDB_OFS_BUF_CTL: begin // RULE12
            next_readdata[`SSPDB_BC_RX_RST] = rx_rst_bit;
            next_readdata[`SSPDB_BC_TX_RST] = tx_rst_bit;
            next_readdata[`SSPDB_BC_RX_CLR] = rx_clr_bit;
            next_readdata[`SSPDB_BC_RX_OV_IE] = rx_ov_ie;
            next_readdata[`SSPDB_BC_TX_CLR] = tx_clr_bit;
            next_readdata[`SSPDB_BC_TX_UDR_IE] = tx_udr_ie;
         end
         `SSPDB_OFS_BUF_STS: begin
            next_readdata[`SSPDB_BS_TX_UDR] = tx_udr_flag;
            next_readdata[`SSPDB_BS_TX_FULL] = tx_full;
            next_readdata[`SSPDB_BS_TX_EMPTY] = ~tx_full; // RULE15
            next_readdata[`SSPDB_BS_RX_OV] = rx_ov_flag;
            next_readdata[`SSPDB_BS_RX_FULL] = rx_full;
            next_readdata[`SSPDB_BS_RX_EMPTY] = ~rx_full;
         end
         `SSPDB_OFS_LINE_CTL: begin
            next_readdata[`SSPDB_LC_WLEN_HI:`SSPDB_LC_WLEN_LO] = wlen_sel;
         end
         `SSPDB_OFS_IRQ_STS: begin
            next_readdata[1:0] = flags;
         end
         `SSPDB_OFS_IRQ_EN: begin
            next_readdata[1:0] = irq_en;
         end
         default: begin
            next_readdata = `SSPDB_ZERO32;
         end
      endcase
   end

   // ==========================================================
   // Control and configuration registers
   always @(posedge core_clk_in) begin
      if (srst_in) begin // RULE12
         rx_rst_bit <= 1'b0;
         tx_rst_bit <= 1'b0;
         rx_clr_bit <= 1'b0;
         tx_clr_bit <= 1'b0;
         rx_ov_ie <= 1'b0;
         tx_udr_ie <= 1'b0;
         wlen_sel <= `SSPDB_RST_WLEN;
         irq_en <= `SSPDB_RST_IRQ_EN;
      end else begin
         rx_rst_bit <= wr_bc & be[`SSPDB_BC_RX_RST/8] &
                       wdata[`SSPDB_BC_RX_RST]; // RULE6
         tx_rst_bit <= wr_bc & be[`SSPDB_BC_TX_RST/8] &
                       wdata[`SSPDB_BC_TX_RST]; // RULE6
         rx_clr_bit <= wr_bc & be[`SSPDB_BC_RX_CLR/8] &
                       wdata[`SSPDB_BC_RX_CLR]; // RULE6
         tx_clr_bit <= wr_bc & be[`SSPDB_BC_TX_CLR/8] &
                       wdata[`SSPDB_BC_TX_CLR]; // RULE6
         if (wr_bc && be[`SSPDB_BC_RX_OV_IE/8]) begin
            rx_ov_ie <= wdata[`SSPDB_BC_RX_OV_IE]; // RULE10
         end
         if (wr_bc && be[`SSPDB_BC_TX_UDR_IE/8]) begin
            tx_udr_ie <= wdata[`SSPDB_BC_TX_UDR_IE]; // RULE11
         end
         if (wr_lc && be[`SSPDB_LC_WLEN_LO/8]) begin
            wlen_sel <= wdata[`SSPDB_LC_WLEN_HI:`SSPDB_LC_WLEN_LO];
         end
         if (wr_ien && be[0]) begin
            irq_en <= wdata[1:0];
         end
      end
   end

   // ==========================================================
   // Transmit buffer
   always @(posedge core_clk_in) begin
      if (srst_in || tx_path_rst || tx_clr_bit) begin // RULE5 RULE8
         tx_buf <= `SSPDB_ZERO16;
         tx_full <= 1'b0;
      end else begin
         if (tx_load) begin
            tx_full <= 1'b0;
         end
         if (wr_tx && (be[0] || be[1])) begin // RULE1
            if (be[0]) begin
               tx_buf[7:0] <= wdata[7:0];
            end
            if (be[1]) begin
               tx_buf[15:8] <= wdata[15:8];
            end
            tx_full <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Receive buffer
   always @(posedge core_clk_in) begin
      if (srst_in || rx_path_rst || rx_clr_bit) begin // RULE4 RULE7
         rx_buf <= `SSPDB_ZERO16;
         rx_full <= 1'b0;
      end else begin
         if (rd && rd_pop_ok) begin
            rx_full <= 1'b0;
         end
         if (word_done && !rx_full) begin
            rx_buf <= rx_word; // RULE3 RULE16
            rx_full <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Sticky event flags, set wins over clear
   assign clr_ov = (wr_bs & be[`SSPDB_BS_RX_OV/8] &
                    wdata[`SSPDB_BS_RX_OV]) |
                   (wr_iclr & be[0] & wdata[`SSPDB_IRQ_RX_OV]);
   assign clr_udr = (wr_bs & be[`SSPDB_BS_TX_UDR/8] &
                     wdata[`SSPDB_BS_TX_UDR]) |
                    (wr_iclr & be[0] & wdata[`SSPDB_IRQ_TX_UDR]);

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         rx_ov_flag <= 1'b0;
         tx_udr_flag <= 1'b0;
      end else begin
         if (ov_evt) begin
            rx_ov_flag <= 1'b1; // RULE13
         end else if (clr_ov) begin
            rx_ov_flag <= 1'b0; // RULE13
         end
         if (udr_evt) begin
            tx_udr_flag <= 1'b1; // RULE14
         end else if (clr_udr) begin
            tx_udr_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Interrupt output
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= (rx_ov_flag & rx_ov_ie &
                     irq_en[`SSPDB_IRQ_RX_OV]) | // RULE10
                    (tx_udr_flag & tx_udr_ie &
                     irq_en[`SSPDB_IRQ_TX_UDR]); // RULE11
      end
   end

endmodule // sspdb_top
`default_nettype wire

// file: test/sspdb_assertions.sv
// Purpose: Port checker for the serial buffer block
// Assumes: Sees only the ports of sspdb_top
// Notes: Tracks enables and word length from accepted writes
`timescale 1ns/100ps
`default_nettype none

module sspdb_checker (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // Register bus
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Link and interrupt
   input wire logic spi_clk_in,
   input wire logic spi_sel_n_in,
   input wire logic spi_mosi_in,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe_out,
   input wire logic irq_out
);
   // ==========================================================
   // Helper state
   logic acc_w, acc_r, mapped, ov_ok, ud_ok, en14, en6;
   logic [1:0] ie;
   logic [3:0] wlen;
   logic [31:0] rx_mask;
   logic [7:0] a;
   assign a = avs_address_in;
   assign acc_w = avs_write_in && !avs_waitrequest_out;
   assign acc_r = avs_read_in && !avs_waitrequest_out;
   assign mapped = a[1:0] == 2'h0 && a >= 8'h2c && a <= 8'h48;
   assign ov_ok = en14 && ie[0];
   assign ud_ok = en6 && ie[1];
   assign rx_mask = (wlen < 4'h4) ? 32'h0000ffff :
      (32'h00000001 << wlen) - 32'h00000001;
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         wlen <= 4'h0;
         ie <= 2'h0;
         en14 <= 1'b0;
         en6 <= 1'b0;
      end else if (acc_w) begin
         if (a == 8'h2c && avs_byteenable_in[1])
            wlen <= avs_writedata_in[11:8];
         if (a == 8'h48 && avs_byteenable_in[0])
            ie <= avs_writedata_in[1:0];
         if (a == 8'h38 && avs_byteenable_in[1])
            en14 <= avs_writedata_in[14];
         if (a == 8'h38 && avs_byteenable_in[0])
            en6 <= avs_writedata_in[6];
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   property p_wait;
      (avs_read_in || avs_write_in) && avs_waitrequest_out
         |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait cycle count wrong");
   property p_tx_ro;
      acc_r && a == 8'h30 |-> avs_readdata_out == 32'h00000000;
   endproperty
   a_tx_ro: assert property (p_tx_ro)
      else $error("transmit word readable");
   property p_rx_align;
      acc_r && a == 8'h34 |-> (avs_readdata_out & ~rx_mask) == 32'h0;
   endproperty
   a_rx_align: assert property (p_rx_align)
      else $error("receive word not right aligned");
   property p_ctl_rsv;
      acc_r && a == 8'h38 |-> (avs_readdata_out & 32'hfffc3f3f) == 32'h0;
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv)
      else $error("control reserved bits set");
   property p_sts_rsv;
      acc_r && a == 8'h3c |-> (avs_readdata_out & 32'hfffff4f4) == 32'h0;
   endproperty
   a_sts_rsv: assert property (p_sts_rsv)
      else $error("status reserved bits set");
   property p_unmap;
      acc_r && !mapped |-> avs_readdata_out == 32'h00000000;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_irq_ov;
      irq_out && !$past(ud_ok, 1) && !$past(ud_ok, 2)
         |-> $past(ov_ok, 1) || $past(ov_ok, 2);
   endproperty
   a_irq_ov: assert property (p_irq_ov)
      else $error("overrun interrupt not gated");
   property p_irq_ud;
      irq_out && !$past(ov_ok, 1) && !$past(ov_ok, 2)
         |-> $past(ud_ok, 1) || $past(ud_ok, 2);
   endproperty
   a_irq_ud: assert property (p_irq_ud)
      else $error("under-run interrupt not gated");
   property p_oe;
      spi_miso_oe_out == !$past(spi_sel_n_in, 3);
   endproperty
   a_oe: assert property (p_oe)
      else $error("miso enable does not follow select");
endmodule // sspdb_checker

bind sspdb_top sspdb_checker chk (.core_clk_in, .srst_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_readdata_out, .avs_waitrequest_out, .spi_clk_in, .spi_sel_n_in,
   .spi_mosi_in, .spi_miso_out, .spi_miso_oe_out, .irq_out);
`default_nettype wire

// file: test/sspdb_spi_peer.sv
// Purpose: Serial link master facing the block
// Assumes: Mode 0, MSB first, 320 ns link clock
// Notes: Link clock stands low between frames
`timescale 1ns/100ps
`default_nettype none

module sspdb_spi_peer (
   // Link outputs
   output var logic sclk_out,
   output var logic sel_n_out,
   output var logic mosi_out,
   // Link input
   input wire logic miso_in
);
   initial begin
      sclk_out = 1'b0;
      sel_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // One word of n bits; miso read just before each fall
   task automatic frame(input logic [15:0] tx, input int n,
      output logic [15:0] rx);
      rx = 16'h0000;
      sel_n_out <= 1'b0;
      #400;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_out <= tx[i];
         #160 sclk_out <= 1'b1;
         #150 rx[i] = miso_in;
         #10 sclk_out <= 1'b0;
      end
      #400 sel_n_out <= 1'b1;
      mosi_out <= ~mosi_out;
   endtask
endmodule // sspdb_spi_peer
`default_nettype wire

// file: test/tb_top.sv
// Purpose: Self-checking bench of the serial buffer block
// Assumes: Bus and link peer driven from here
// Notes: Byte lanes held all on
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   localparam logic [31:0] all_bits = 32'hffffffff;
   logic core_clk_in, srst_in, avs_read_in, avs_write_in, irq_out;
   logic [7:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic [3:0] avs_byteenable_in;
   logic avs_waitrequest_out, spi_clk_in, spi_sel_n_in, spi_mosi_in;
   logic spi_miso_out, spi_miso_oe_out;
   int failures, n_compared;

   sspdb_top dut (.core_clk_in, .srst_in, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
      .avs_readdata_out, .avs_waitrequest_out, .spi_clk_in, .spi_sel_n_in,
      .spi_mosi_in, .spi_miso_out, .spi_miso_oe_out, .irq_out);
   sspdb_spi_peer peer (.sclk_out(spi_clk_in), .sel_n_out(spi_sel_n_in),
      .mosi_out(spi_mosi_in), .miso_in(spi_miso_out));

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      do begin
         @(posedge core_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] m, e,
      input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, e, q & m);
   endtask
   task automatic xfer(input logic [15:0] tx, input int n,
      input logic [15:0] e, input string what);
      logic [15:0] rx;
      peer.frame(tx, n, rx);
      repeat (4) @(posedge core_clk_in);
      chk(what, {16'h0, e}, {16'h0, rx});
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge core_clk_in);
      chk("irq", {31'h0, e}, {31'h0, irq_out});
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rreg(8'h38, all_bits, 32'h0, "ctl");
      rreg(8'h3c, all_bits, 32'h101, "sts");
      rreg(8'h34, all_bits, 32'h0, "rx");
      $display("t_reset done");
   endtask
   task automatic t_txrx;
      wreg(8'h30, 32'hffffa5c3);
      rreg(8'h30, all_bits, 32'h0, "tx read");
      rreg(8'h3c, 32'h300, 32'h200, "tx full");
      xfer(16'h3c5a, 16, 16'ha5c3, "miso");
      rreg(8'h34, all_bits, 32'h3c5a, "rx");
      rreg(8'h3c, 32'h3, 32'h1, "rx pop");
      $display("t_txrx done");
   endtask
   task automatic t_wlen;
      wreg(8'h2c, 32'h800);
      wreg(8'h30, 32'h1ab);
      xfer(16'h05e5, 8, 16'h00ab, "miso 8");
      rreg(8'h34, all_bits, 32'he5, "rx 8");
      wreg(8'h2c, 32'h0);
      $display("t_wlen done");
   endtask
   task automatic t_ovr;
      wreg(8'h44, 32'h3);
      wreg(8'h48, 32'h3);
      wreg(8'h38, 32'h4000);
      xfer(16'h1111, 16, 16'h0, "udr miso");
      irq_is(1'b0);
      xfer(16'h2222, 16, 16'h0, "udr miso");
      irq_is(1'b1);
      rreg(8'h3c, 32'h90b, 32'h90a, "flags");
      rreg(8'h40, all_bits, 32'h3, "irq flags");
      rreg(8'h34, all_bits, 32'h1111, "kept");
      wreg(8'h38, 32'h0);
      irq_is(1'b0);
      wreg(8'h3c, 32'h8);
      rreg(8'h3c, 32'h8, 32'h0, "ov w1c");
      wreg(8'h38, 32'h40);
      irq_is(1'b1);
      wreg(8'h44, 32'h2);
      irq_is(1'b0);
      $display("t_ovr done");
   endtask
   task automatic t_clr;
      xfer(16'h3333, 16, 16'h0, "miso empty");
      wreg(8'h30, 32'h1234);
      wreg(8'h38, 32'hfffcffff);
      rreg(8'h38, all_bits, 32'h4040, "ctl");
      rreg(8'h3c, all_bits, 32'h901, "cleared");
      wreg(8'h44, 32'h3);
      $display("t_clr done");
   endtask
   task automatic t_rst;
      xfer(16'h4444, 16, 16'h0, "miso empty");
      wreg(8'h30, 32'h5678);
      wreg(8'h38, 32'h34040);
      rreg(8'h3c, 32'h303, 32'h101, "reset");
      rreg(8'h34, all_bits, 32'h0, "rx reset");
      xfer(16'h5555, 16, 16'h0, "tx reset");
      wreg(8'h34, 32'hffff);
      rreg(8'h34, all_bits, 32'h5555, "rx ro");
      rreg(8'h00, all_bits, 32'h0, "unmapped");
      wreg(8'h4c, all_bits);
      rreg(8'h4c, all_bits, 32'h0, "unmapped");
      $display("t_rst done");
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   initial begin
      srst_in = 1'b1;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 8'h00;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'hf;
      failures = 0;
      n_compared = 0;
      repeat (8) @(posedge core_clk_in);
      srst_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      t_reset;
      t_txrx;
      t_wlen;
      t_ovr;
      t_clr;
      t_rst;
      conclude;
   end
   initial begin
      #400000;
      failures++;
      conclude;
   end
endmodule // tb_top
`default_nettype wire
